//--- hdl/dcc_pkg.sv
/*
  Shared constants for the oscillator clock-source control block: APB register
  offsets, field positions, reset values and range thresholds.
  Assumes a 32-bit APB bus with word-aligned registers.
*/
package dcc_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFF_RANGE_CTRL = 12'h000;
  localparam logic [11:0] OFF_FREQ_CTRL  = 12'h004;
  localparam logic [11:0] OFF_CLK_SEL    = 12'h008;
  localparam logic [11:0] OFF_FLAGS      = 12'h00c;
  localparam logic [11:0] OFF_STATUS     = 12'h010;
  localparam logic [3:0] RANGE_RESET   = 4'h7;
  localparam logic [3:0] RANGE_DEFAULT = 4'h7;
  localparam logic [3:0] RANGE_MID     = 4'hd;
  localparam logic [3:0] RANGE_LOW_TOP = 4'hc;
  localparam logic [3:0] RANGE_MAX     = 4'hf;
  localparam logic [7:0] FREQ_RESET    = 8'h60;
  localparam logic [1:0] MSEL_RESET    = 2'h0;
  localparam int unsigned STEP_POS = 5;
  localparam int unsigned MOD_POS  = 0;
  localparam int unsigned FLAG_FAULT_POS  = 0;
  localparam int unsigned FLAG_GENOFF_POS = 1;
  localparam int unsigned SEL_MAIN_POS = 0;
  localparam int unsigned SEL_SUB_POS  = 2;
  localparam int unsigned DWELL_CYCLES = 4;
  typedef enum logic [1:0] {
    DCC_IDLE = 2'b00,
    DCC_STEP = 2'b01,
    DCC_WAIT = 2'b11
  } dcc_state_e;
endpackage

//--- hdl/dcc_top.sv
/*
  Oscillator clock-source control: APB register slave, oscillator enable and
  dc generator control, and a range sequencer that walks the range field one
  step per update toward a requested target.
  Assumes one 100 MHz APB clock and an APB master that obeys the protocol.
*/
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module dcc_top #(
  parameter int unsigned DWELL = dcc_pkg::DWELL_CYCLES
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [dcc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            osc_enable,
  output logic                            osc_dc_gen_on,
  output logic                            main_clock_uses_osc,
  output logic                            subsystem_clock_uses_osc,
  output logic      [3:0]                 dco_range_value,
  output logic      [2:0]                 osc_step_field,
  output logic      [4:0]                 osc_modulation_field,
  output logic                            range_busy
);
  import dcc_pkg::*;

  typedef struct packed {
    logic [3:0]  range;
    logic [3:0]  target;
    logic [7:0]  freq;
    logic [1:0]  main_sel;
    logic        sub_sel;
    logic        fault;
    logic        gen_off;
    dcc_state_e  st;
    logic [7:0]  dwell;
    logic [31:0] rdata;
  } dcc_s;

  dcc_s s_q;
  dcc_s s_d;

  logic wr;
  logic rd;
  logic hit;

  function automatic logic main_sel_osc(input logic [1:0] sel);
    return sel[1] == 1'b0;
  endfunction

  always_comb begin
    wr  = psel & penable & pwrite;
    // Read data is captured in the setup cycle so that it stands from a flop through the access cycle.
    rd  = psel & ~penable & ~pwrite;
    hit = (paddr == OFF_RANGE_CTRL) || (paddr == OFF_FREQ_CTRL) || (paddr == OFF_CLK_SEL) ||
          (paddr == OFF_FLAGS) || (paddr == OFF_STATUS);
  end

  always_comb begin
    s_d = s_q;
    if (wr) begin
      unique case (paddr)
        OFF_RANGE_CTRL: begin
          if (s_q.st == DCC_IDLE && pwdata[3:0] != s_q.range) begin
            s_d.target = pwdata[3:0];
            s_d.st     = DCC_STEP;
          end
        end
        OFF_FREQ_CTRL: begin
          s_d.freq = pwdata[7:0];
        end
        OFF_CLK_SEL: begin
          s_d.main_sel = pwdata[SEL_MAIN_POS +: 2];
          s_d.sub_sel  = pwdata[SEL_SUB_POS];
        end
        OFF_FLAGS: begin
          s_d.fault   = pwdata[FLAG_FAULT_POS];
          s_d.gen_off = pwdata[FLAG_GENOFF_POS];
        end
        default: begin
        end
      endcase
    end
    unique case (s_q.st)
      DCC_IDLE: begin
        s_d.dwell = 8'h00;
      end
      DCC_STEP: begin
        if (s_q.range < s_q.target) begin
          s_d.range = s_q.range + 4'h1;
        end else if (s_q.range > s_q.target) begin
          s_d.range = s_q.range - 4'h1;
        end
        s_d.dwell = 8'h00;
        s_d.st    = DCC_WAIT;
      end
      DCC_WAIT: begin
        // Each step dwells so the oscillator settles before the next move.
        if (s_q.dwell >= 8'(DWELL - 1)) begin
          s_d.st = (s_q.range == s_q.target) ? DCC_IDLE : DCC_STEP;
        end else begin
          s_d.dwell = s_q.dwell + 8'h01;
        end
      end
      default: begin
        s_d.st = DCC_IDLE;
      end
    endcase
    s_d.rdata = 32'h0;
    if (rd) begin
      unique case (paddr)
        OFF_RANGE_CTRL: s_d.rdata = {28'h0, s_q.range};
        OFF_FREQ_CTRL:  s_d.rdata = {24'h0, s_q.freq};
        OFF_CLK_SEL:    s_d.rdata = {29'h0, s_q.sub_sel, s_q.main_sel};
        OFF_FLAGS:      s_d.rdata = {30'h0, s_q.gen_off, s_q.fault};
        OFF_STATUS:     s_d.rdata = {22'h0, osc_dc_gen_on, osc_enable, s_q.target, 3'h0, range_busy};
        default:        s_d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.range    <= RANGE_RESET;
      s_q.target   <= RANGE_RESET;
      s_q.freq     <= FREQ_RESET;
      s_q.main_sel <= MSEL_RESET;
      s_q.sub_sel  <= 1'b0;
      s_q.fault    <= 1'b0;
      s_q.gen_off  <= 1'b0;
      s_q.st       <= DCC_IDLE;
      s_q.dwell    <= 8'h00;
      s_q.rdata    <= 32'h0;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    main_clock_uses_osc      = main_sel_osc(s_q.main_sel);
    subsystem_clock_uses_osc = s_q.sub_sel;
    // Enable from main select or fault.
    osc_enable    = main_clock_uses_osc | s_q.fault;
    osc_dc_gen_on = ~(s_q.gen_off & ~main_clock_uses_osc & ~subsystem_clock_uses_osc & ~s_q.fault);
    dco_range_value      = s_q.range;
    osc_step_field       = s_q.freq[STEP_POS +: 3];
    osc_modulation_field = s_q.freq[MOD_POS +: 5];
    range_busy = (s_q.st != DCC_IDLE);
    prdata     = s_q.rdata;
    pready     = psel & penable;
    pslverr    = psel & penable & ~hit;
  end
endmodule // dcc_top

//--- test/dcc_top_checker.sv
/* Port checker for dcc_top.
   Assumes it is bound to dcc_top and sees only its ports. */
`timescale 1ns/1ps
module dcc_top_checker #(
  parameter int unsigned DWELL = 4
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       osc_enable,
  input wire logic       osc_dc_gen_on,
  input wire logic       main_clock_uses_osc,
  input wire logic       subsystem_clock_uses_osc,
  input wire logic [3:0] dco_range_value,
  input wire logic       range_busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  main_start_a: assert property (main_clock_uses_osc |-> osc_enable)
    else $error("main clock uses osc while osc off");
  gen_keep_a: assert property (osc_enable || subsystem_clock_uses_osc |-> osc_dc_gen_on)
    else $error("dc generator off while osc in use");
  reset_range_a: assert property ($rose(presetn) |-> dco_range_value == 4'h7)
    else $error("range not 7 after reset");
  one_step_a: assert property ($changed(dco_range_value) |-> 4'(dco_range_value - $past(dco_range_value)) inside {4'h1, 4'hf})
    else $error("range moved more than one step");
  step_busy_a: assert property ($changed(dco_range_value) |-> range_busy)
    else $error("range moved while not busy");
  dwell_hold_a: assert property ($changed(dco_range_value) |=> $stable(dco_range_value)[*3])
    else $error("range steps too close");
  busy_end_a: assert property ($rose(range_busy) |-> ##[1:200] !range_busy)
    else $error("busy never ends");
  apb_ready_a: assert property (pready == (psel && penable))
    else $error("pready not zero wait");
  cover property ($rose(range_busy));
  cover property (!osc_dc_gen_on);
  cover property (subsystem_clock_uses_osc && !osc_enable);
endmodule // dcc_top_checker

bind dcc_top dcc_top_checker #(.DWELL(DWELL)) u_chk (.*);

//--- test/tb_top.sv
/* Self-checking bench for dcc_top.
   Assumes an APB master here and the default dwell count. */
`timescale 1ns/1ps
module tb_top;
  import dcc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        osc_enable, osc_dc_gen_on, main_clock_uses_osc, subsystem_clock_uses_osc, range_busy;
  logic [3:0]  dco_range_value;
  logic [2:0]  osc_step_field;
  logic [4:0]  osc_modulation_field;
  int          num_errors = 0, compares = 0;
  always #5 pclk = ~pclk;
  dcc_top u_dut (.*);
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic walk(input logic [3:0] tgt, input logic [3:0] exp);
    apb(1, OFF_RANGE_CTRL, 32'(tgt));
    for (int n = 0; n < 200 && range_busy !== 1'b0; n++) @(posedge pclk);
    chk(32'(dco_range_value), 32'(exp));
  endtask
  task automatic t_startup;
    apb(1, OFF_FREQ_CTRL, 32'h0);
    chk({osc_step_field, osc_modulation_field}, 8'h00);
    walk(4'h8, 4'h8);
    apb(1, OFF_FREQ_CTRL, 32'h60);
    chk({osc_step_field, osc_modulation_field}, 8'h60);
  endtask
  task automatic t_select;
    for (int m = 3; m >= 0; m--) begin
      apb(1, OFF_CLK_SEL, 32'(m));
      chk({main_clock_uses_osc, osc_enable}, {2{m < 2}});
    end
    apb(1, OFF_CLK_SEL, 32'h6);
    chk({subsystem_clock_uses_osc, osc_enable}, 2'b10);
  endtask
  task automatic t_gen;
    apb(1, OFF_CLK_SEL, 32'h2);
    apb(1, OFF_FLAGS, 32'h2);
    chk(osc_dc_gen_on, 0);
    apb(1, OFF_FLAGS, 32'h3);
    chk({osc_enable, osc_dc_gen_on}, 2'b11);
    apb(1, OFF_FLAGS, 32'h2);
    chk(osc_enable, 0);
    apb(1, OFF_CLK_SEL, 32'h6);
    chk(osc_dc_gen_on, 1);
  endtask
  task automatic t_range;
    apb(1, OFF_RANGE_CTRL, 32'h9);
    chk(range_busy, 1);
    walk(4'h3, 4'h9);
    chk(dco_range_value, 4'h9);
    walk(4'h7, 4'h7);
    walk(4'hf, 4'hf);
    walk(4'h7, 4'h7);
    apb(1, OFF_FREQ_CTRL, 32'ha5);
    chk({osc_step_field, osc_modulation_field}, 8'ha5);
    walk(4'hd, 4'hd);
    walk(4'h3, 4'h3);
    apb(0, OFF_RANGE_CTRL, 0);
    chk(rd, 32'h3);
    apb(0, 12'h020, 0);
    chk({err, rd}, 33'h100000000);
  endtask
  task automatic final_report;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100us;
    num_errors++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk({dco_range_value, range_busy, osc_enable}, 6'h1d);
    t_startup();
    t_select();
    t_gen();
    t_range();
    final_report();
  end
endmodule // tb_top
